// file: e3_tx_pkg.sv
// Shared constants, enumerations and carrier structs for the E3 transmit overhead block
package e3_tx_pkg;
  // Wishbone geometry
  localparam int unsigned ADR_W = 12;
  localparam int unsigned DAT_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [9:0] TX_CTRL_IDX = 10'h118;
  localparam logic [9:0] TX_ERR_IDX = 10'h11A;
  // Reset values
  localparam logic [15:0] TX_CTRL_RST = 16'h0000;
  localparam logic [15:0] TX_ERR_RST = 16'h0000;
  // Writable bits; reserved bits stay zero
  localparam logic [15:0] TX_CTRL_MASK = 16'h030F;
  localparam logic [15:0] TX_ERR_MASK = 16'h001F;
  // Control register field positions
  localparam int unsigned N_SEL_LSB = 8;
  localparam int unsigned A_SEL_LSB = 2;
  localparam int unsigned FGD_BIT = 1;
  localparam int unsigned AIS_BIT = 0;
  // Error insertion register field positions
  localparam int unsigned ERR_TYPE_LSB = 3;
  localparam int unsigned ERR_EN_BIT = 2;
  localparam int unsigned SW_INS_BIT = 1;
  localparam int unsigned TRIG_SEL_BIT = 0;
  // Frame layout
  localparam int unsigned FRAME_BITS_DEF = 1536;
  localparam logic [10:0] FAS_LEN = 11'h00A;
  localparam logic [10:0] A_POS = 11'h00A;
  localparam logic [10:0] N_POS = 11'h00B;
  localparam logic [3:0] FAS_MSB = 4'h9;
  localparam logic [9:0] FAS_WORD = 10'h3D0;
  // Frames hit by one error request
  localparam logic [2:0] SINGLE_FRAMES = 3'h1;
  localparam logic [2:0] BURST_FRAMES = 3'h4;

  // N bit sources
  typedef enum logic [1:0] {
    N_ONE = 2'b00,
    N_HDLC = 2'b01,
    N_FEAC = 2'b10,
    N_ZERO = 2'b11
  } n_src_t;
  // A bit sources
  typedef enum logic [1:0] {
    A_AUTO = 2'b00,
    A_FEAC = 2'b01,
    A_ZERO = 2'b10,
    A_ONE = 2'b11
  } a_src_t;
  // Framing error kinds
  typedef enum logic [1:0] {
    ERR_BIT_ONE = 2'b00,
    ERR_WORD_ONE = 2'b01,
    ERR_BIT_FOUR = 2'b10,
    ERR_WORD_FOUR = 2'b11
  } err_type_t;
  // Burst sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BURST = 1'b1
  } burst_state_t;

  // Receive-side defect levels
  typedef struct packed {
    logic lof;
    logic ais;
    logic oof;
    logic los;
  } rx_alarm_t;
  // Receive-side remote alarm enable and disable bits
  typedef struct packed {
    logic lof_en;
    logic ais_dis;
    logic oof_dis;
    logic los_dis;
  } rai_cfg_t;
endpackage

// file: err_trigger_capture.sv
// Error request capture: pin synchroniser, trigger select and pending flag
`timescale 1ns/1ps
`default_nettype none
module err_trigger_capture (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_sel_i,
  input wire logic sw_insert_i,
  input wire logic ext_insert_i,
  input wire logic enable_i,
  input wire logic consume_i,
  output logic pending_o
);
  logic ext_meta_reg; // First synchroniser stage
  logic ext_sync_reg; // Second synchroniser stage
  logic level_prev_reg; // Selected trigger level, one cycle old
  logic sel_level; // Trigger level after source select
  logic rise; // Rising edge of selected trigger

  // Two-stage synchroniser for the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_insert_i;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // Source select; switching while a source is high can make an edge
  assign sel_level = trig_sel_i ? ext_sync_reg : sw_insert_i;
  assign rise = sel_level & ~level_prev_reg;

  // Edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_prev_reg <= 1'b0;
    end else begin
      level_prev_reg <= sel_level;
    end
  end

  // Pending flag: many edges fold into one; set wins over consume
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_o <= 1'b0;
    end else if (rise && enable_i) begin
      pending_o <= 1'b1;
    end else if (consume_i) begin
      pending_o <= 1'b0;
    end
  end

  // A consume that meets no new edge empties the flag
  single_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                 consume_i && !(rise && enable_i) |=> !pending_o)
    else $error("request not consumed");
endmodule
`default_nettype wire

// file: e3_tx_overhead_error_insert.sv
// E3 transmit overhead source select, alarm forcing and framing error insertion
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - N bit: one, HDLC, FEAC or zero
// - A bit: auto alarm, FEAC, zero or one
// - Both on FEAC share one stream
// - Generation disable passes overhead through unchanged
// - Errors and alarm still overwrite when disabled
// - Alarm bit forces every output bit one
// - Error type: bit/word, one/four frames
// - No insertion while insertion enable is zero; a burst already running still errors its remaining frames
// - Software bit rising edge requests one error
// - Repeated edges before opportunity give one error
// - Trigger select: software bit or external pin
// - Changing trigger select may insert one error
// - Auto A bit reports receive defects
module e3_tx_overhead_error_insert #(
  parameter int unsigned FRAME_BITS = e3_tx_pkg::FRAME_BITS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [e3_tx_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [e3_tx_pkg::DAT_W-1:0] wb_dat_i,
  output logic [e3_tx_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Incoming payload stream
  input wire logic tx_valid_i,
  input wire logic tx_sof_i,
  input wire logic tx_data_i,
  // Overhead sources
  input wire logic hdlc_bit_i,
  input wire logic feac_bit_i,
  input wire e3_tx_pkg::rx_alarm_t rx_alarm_i,
  input wire e3_tx_pkg::rai_cfg_t rai_cfg_i,
  // External error trigger pin
  input wire logic ext_err_insert_in_i,
  // Outgoing line stream
  output logic tx_valid_o,
  output logic tx_data_o,
  output logic tx_sof_o
);
  import e3_tx_pkg::*;

  localparam logic [10:0] FRAME_LAST = 11'(FRAME_BITS - 1); // Last bit position

  logic [15:0] tx_ctrl_reg; // Control register
  logic [15:0] tx_err_reg; // Error insertion register
  logic [10:0] pos_reg; // Position of the next bit
  logic [10:0] cur_pos; // Position of the bit in flight
  logic feac_reg; // FEAC bit held for the frame
  logic feac_now; // FEAC bit for the bit in flight
  logic [2:0] left_reg; // Errored frames left, current included
  logic [2:0] left_now; // Errored frames count for the bit in flight
  logic word_reg; // Burst uses word errors
  logic word_now; // Word flag for the bit in flight
  burst_state_t state_reg; // Burst sequencer state
  burst_state_t state_next; // Next sequencer state
  logic [2:0] left_next; // Next frames-left value
  logic word_next; // Next word flag
  logic opportunity; // First bit of a frame
  logic pending; // Error requested, not yet applied
  logic start; // Request taken at this opportunity
  logic rai; // Automatic remote alarm level
  logic n_bit; // Selected N bit value
  logic a_bit; // Selected A bit value
  logic bit_next; // Outgoing bit value
  logic fas_exp; // Generated framing bit, used by output and assertions
  logic wb_req; // New bus request
  logic wb_wr; // Write takes effect now
  logic [15:0] rd_data; // Read data mux
  logic [15:0] wr_mask; // Byte lane mask

  // Control field views
  n_src_t n_sel;
  a_src_t a_sel;
  err_type_t err_type;
  logic fgd;
  logic ais;
  logic err_en;

  assign n_sel = n_src_t'(tx_ctrl_reg[N_SEL_LSB +: 2]);
  assign a_sel = a_src_t'(tx_ctrl_reg[A_SEL_LSB +: 2]);
  assign fgd = tx_ctrl_reg[FGD_BIT];
  assign ais = tx_ctrl_reg[AIS_BIT];
  assign err_type = err_type_t'(tx_err_reg[ERR_TYPE_LSB +: 2]);
  assign err_en = tx_err_reg[ERR_EN_BIT];

  // Register index from a byte address
  function automatic logic [9:0] reg_index(input logic [ADR_W-1:0] adr);
    reg_index = adr[ADR_W-1:2];
  endfunction

  // Framing word bit for a position, first bit sent is the MSB
  function automatic logic fas_bit(input logic [10:0] pos);
    logic [3:0] idx;
    idx = FAS_MSB - pos[3:0];
    fas_bit = FAS_WORD[idx];
  endfunction

  // Bus handshake terms
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Read mux, unmapped addresses read zero
  always_comb begin
    if (reg_index(wb_adr_i) == TX_CTRL_IDX) begin
      rd_data = tx_ctrl_reg;
    end else if (reg_index(wb_adr_i) == TX_ERR_IDX) begin
      rd_data = tx_err_reg;
    end else begin
      rd_data = 16'h0000;
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req) begin
      wb_dat_o <= {16'h0000, rd_data};
    end
  end

  // Register writes at the acked edge, reserved bits held zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ctrl_reg <= TX_CTRL_RST;
      tx_err_reg <= TX_ERR_RST;
    end else if (wb_wr) begin
      if (reg_index(wb_adr_i) == TX_CTRL_IDX) begin
        tx_ctrl_reg <= (tx_ctrl_reg & ~wr_mask) | (wb_dat_i[15:0] & wr_mask & TX_CTRL_MASK);
      end else if (reg_index(wb_adr_i) == TX_ERR_IDX) begin
        tx_err_reg <= (tx_err_reg & ~wr_mask) | (wb_dat_i[15:0] & wr_mask & TX_ERR_MASK);
      end
    end
  end

  // Frame position; start-of-frame realigns
  assign cur_pos = tx_sof_i ? 11'h000 : pos_reg;
  assign opportunity = tx_valid_i & (cur_pos == 11'h000);

  // Bit position counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= 11'h000;
    end else if (tx_valid_i) begin
      pos_reg <= (cur_pos == FRAME_LAST) ? 11'h000 : cur_pos + 11'h001;
    end
  end

  // One FEAC bit per frame, shared by N and A
  assign feac_now = opportunity ? feac_bit_i : feac_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feac_reg <= 1'b0;
    end else if (opportunity) begin
      feac_reg <= feac_bit_i;
    end
  end

  // Request capture and trigger select
  err_trigger_capture u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_sel_i(tx_err_reg[TRIG_SEL_BIT]),
    .sw_insert_i(tx_err_reg[SW_INS_BIT]),
    .ext_insert_i(ext_err_insert_in_i),
    .enable_i(err_en),
    .consume_i(start),
    .pending_o(pending)
  );

  // Request taken at a frame start when no burst runs
  assign start = opportunity & pending & err_en & (state_reg == ST_IDLE);

  // Burst sequencer next state
  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    word_next = word_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_BURST;
          word_next = (err_type == ERR_WORD_ONE) || (err_type == ERR_WORD_FOUR);
          left_next = ((err_type == ERR_BIT_FOUR) || (err_type == ERR_WORD_FOUR)) ? BURST_FRAMES
                      : SINGLE_FRAMES;
        end
      end
      ST_BURST: begin
        if (opportunity) begin
          if (left_reg > SINGLE_FRAMES) begin
            left_next = left_reg - SINGLE_FRAMES;
          end else begin
            left_next = 3'h0;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        left_next = 3'h0;
      end
    endcase
  end

  // Burst applies to the frame that starts now
  assign left_now = opportunity ? left_next : left_reg;
  assign word_now = opportunity ? word_next : word_reg;

  // Burst sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      left_reg <= 3'h0;
      word_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
      word_reg <= word_next;
    end
  end

  // Automatic remote alarm from receive defects
  assign rai = (rx_alarm_i.los & ~rai_cfg_i.los_dis) | (rx_alarm_i.oof & ~rai_cfg_i.oof_dis)
               | (rx_alarm_i.ais & ~rai_cfg_i.ais_dis) | (rx_alarm_i.lof & rai_cfg_i.lof_en);

  // N bit source select
  always_comb begin
    case (n_sel)
      N_ONE: n_bit = 1'b1;
      N_HDLC: n_bit = hdlc_bit_i;
      N_FEAC: n_bit = feac_now;
      default: n_bit = 1'b0;
    endcase
  end

  // A bit source select
  always_comb begin
    case (a_sel)
      A_AUTO: a_bit = rai;
      A_FEAC: a_bit = feac_now;
      A_ZERO: a_bit = 1'b0;
      default: a_bit = 1'b1;
    endcase
  end

  assign fas_exp = fas_bit(cur_pos);

  // Outgoing bit: framing, overhead, errors, then alarm
  always_comb begin
    bit_next = tx_data_i;
    if (!fgd) begin
      if (cur_pos < FAS_LEN) begin
        bit_next = fas_exp;
      end else if (cur_pos == A_POS) begin
        bit_next = a_bit;
      end else if (cur_pos == N_POS) begin
        bit_next = n_bit;
      end
    end
    // Errors flip framing bits after any source choice
    if ((left_now != 3'h0) && (cur_pos < FAS_LEN) && (word_now || (cur_pos == 11'h000))) begin
      bit_next = ~bit_next;
    end
    // Alarm overrides everything, errors included
    if (ais) begin
      bit_next = 1'b1;
    end
  end

  // Output stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 1'b0;
      tx_sof_o <= 1'b0;
    end else begin
      tx_valid_o <= tx_valid_i;
      tx_data_o <= tx_valid_i ? bit_next : 1'b0;
      tx_sof_o <= opportunity;
    end
  end

  // Checks run on the line clock and stay quiet in reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Outgoing bits appear one cycle after the input bit
  bus_ack_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack did not follow request for one cycle");
  alarm_ones_a: assert property (tx_valid_i && ais |=> tx_valid_o && tx_data_o)
    else $error("alarm did not force a one");
  n_const_a: assert property (tx_valid_i && !ais && !fgd && cur_pos == N_POS && n_sel == N_ZERO
                               |=> !tx_data_o)
    else $error("N bit not zero");
  a_const_a: assert property (tx_valid_i && !ais && !fgd && cur_pos == A_POS && a_sel == A_ONE
                               |=> tx_data_o)
    else $error("A bit not one");
  feac_share_a: assert property (tx_valid_i && !ais && !fgd && cur_pos == N_POS && n_sel == N_FEAC
                                  |=> tx_data_o == $past(feac_now))
    else $error("N bit lost frame FEAC bit");
  fas_clean_a: assert property (tx_valid_i && !ais && !fgd && cur_pos < FAS_LEN && left_now == 3'h0
                                 |=> tx_data_o == $past(fas_exp))
    else $error("framing word wrong");
  pass_through_a: assert property (tx_valid_i && !ais && fgd && left_now == 3'h0
                                    |=> tx_data_o == $past(tx_data_i))
    else $error("pass-through altered data");
  err_flip_a: assert property (tx_valid_i && !ais && !fgd && cur_pos == 11'h000 && left_now != 3'h0
                                |=> tx_data_o == !$past(fas_exp))
    else $error("error bit not inverted");
  burst_len_a: assert property (start && err_type == ERR_WORD_FOUR |=> left_reg == BURST_FRAMES)
    else $error("burst length wrong");
  disabled_quiet_a: assert property (!err_en && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
    else $error("error started while disabled");
  single_len_a: assert property (start && err_type == ERR_BIT_ONE |=> left_reg == SINGLE_FRAMES && !word_reg)
    else $error("single error length wrong");
  a_auto_a: assert property (tx_valid_i && !ais && !fgd && cur_pos == A_POS && a_sel == A_AUTO
                              |=> tx_data_o == $past(rai))
    else $error("auto A bit does not follow receive defects");
endmodule
`default_nettype wire

// file: e3_line_rx_model.sv
// Line-side receiver model: collects each outgoing frame for the bench
`timescale 1ns/1ps
`default_nettype none
module e3_line_rx_model #(
  parameter int FB = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic sof_i,
  input wire logic data_i,
  output logic [FB-1:0] frame_o,
  output logic [15:0] nfr_o
);
  int p_reg; // Position of the last bit taken
  int p; // Position of the bit now arriving
  logic [FB-1:0] cur_reg; // Bits of the frame so far
  // Start of frame restarts the count
  always_comb begin
    p = sof_i ? 0 : p_reg + 1;
  end
  // Store bits by position; publish the frame with its last bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_reg <= 0;
      nfr_o <= 16'h0000;
    end else if (valid_i) begin
      p_reg <= p;
      if (p < FB) begin
        cur_reg[p] <= data_i;
      end
      if (p == FB - 1) begin
        frame_o <= {data_i, cur_reg[FB-2:0]};
        nfr_o <= nfr_o + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: e3_tx_overhead_error_insert_tb.sv
// Self-checking bench for the E3 transmit overhead and error insertion block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module e3_tx_overhead_error_insert_tb;
  import e3_tx_pkg::*;
  localparam int FB = 64;
  localparam logic [63:0] PAY = 64'h0123_4567_89AB_CDEF; // Payload pattern
  localparam logic [11:0] CTRL = {TX_CTRL_IDX, 2'b00};
  localparam logic [11:0] ERR = {TX_ERR_IDX, 2'b00};
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ext = 1'b0;
  logic hdlc = 1'b0, feac = 1'b1; // Overhead source levels
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic v_o, d_o, s_o;
  rx_alarm_t al = '0;
  rai_cfg_t rc = '0;
  logic [FB-1:0] fr;
  logic [15:0] nfr, q;
  logic [9:0] fas_v, d;
  int pos = 0, n_fail = 0, tests_run = 0, e;
  e3_tx_overhead_error_insert #(.FRAME_BITS(FB)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_valid_i(1'b1),
    .tx_sof_i(pos == 0), .tx_data_i(PAY[pos]), .hdlc_bit_i(hdlc), .feac_bit_i(feac),
    .rx_alarm_i(al), .rai_cfg_i(rc), .ext_err_insert_in_i(ext),
    .tx_valid_o(v_o), .tx_data_o(d_o), .tx_sof_o(s_o));
  e3_line_rx_model #(.FB(FB)) line (.clk_i(clk_i), .rst_i(rst_i), .valid_i(v_o),
    .sof_i(s_o), .data_i(d_o), .frame_o(fr), .nfr_o(nfr));
  // Clock, 50 ns period
  initial forever #25 clk_i = ~clk_i;
  // Payload position counter
  always @(posedge clk_i) pos <= (rst_i || pos == FB - 1) ? 0 : pos + 1;
  task automatic end_sim;
    $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] dv);
    int c;
    c = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {16'h0000, dv};
    do begin @(posedge clk_i); c++; end while (ack !== 1'b1 && c < 20);
    q = rdat[15:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
    if (c >= 20) begin n_fail++; end_sim(); end
  endtask
  // Wait until the line model publishes one more frame
  task automatic wait_fr;
    int c;
    logic [15:0] s;
    s = nfr; c = 0;
    do begin @(posedge clk_i); c++; end while (nfr === s && c < 400);
    if (c >= 400) begin n_fail++; end_sim(); end
  endtask
  // Count frames whose alignment field differs from the reference
  task automatic frames(input int n, input logic [9:0] r);
    e = 0; d = '0;
    for (int k = 0; k < n; k++) begin
      wait_fr();
      if ((fr[9:0] ^ r) !== 10'h000) e++;
      d = d | (fr[9:0] ^ r);
    end
  endtask
  task automatic t_regs;
    wb(0, CTRL, 0); `CHK(q, TX_CTRL_RST)
    wb(0, ERR, 0); `CHK(q, TX_ERR_RST)
    wb(1, CTRL, 16'hFFFF); wb(0, CTRL, 0); `CHK(q, TX_CTRL_MASK)
    wb(1, ERR, 16'hFFF9); wb(0, ERR, 0); `CHK(q, TX_ERR_MASK & 16'hFFF9)
    wb(1, 12'h470, 16'hFFFF); wb(0, 12'h470, 0); `CHK(q, 16'h0000)
    wb(1, CTRL, 0); wb(1, ERR, 0);
  endtask
  task automatic t_sources;
    for (int i = 0; i < 4; i++) begin
      wb(1, CTRL, 16'(i << 8 | i << 2)); wait_fr(); wait_fr();
      `CHK(fr[11:0], {1'(4'b0101 >> i), 1'(4'b1010 >> i), fas_v})
    end
    hdlc <= 1'b1; feac <= 1'b0;
    wb(1, CTRL, 16'h0104); wait_fr(); wait_fr(); `CHK(fr[11:10], 2'b10)
    feac <= 1'b1;
    wb(1, CTRL, 16'h0204); wait_fr(); wait_fr(); `CHK(fr[11:10], 2'b11)
    wb(1, CTRL, 0); al.los <= 1'b1; wait_fr(); wait_fr(); `CHK(fr[10], 1'b1)
    rc.los_dis <= 1'b1; wait_fr(); wait_fr(); `CHK(fr[10], 1'b0)
    al.los <= 1'b0; rc.los_dis <= 1'b0;
    wb(1, CTRL, 16'h0002); wait_fr(); wait_fr(); `CHK(fr, PAY)
    wb(1, CTRL, 16'h0001); wait_fr(); wait_fr(); `CHK(fr, {FB{1'b1}})
    wb(1, CTRL, 0);
  endtask
  task automatic t_err;
    for (int t = 0; t < 4; t++) begin
      wb(1, ERR, 16'(t << 3 | 4)); wait_fr(); wb(1, ERR, 16'(t << 3 | 6)); frames(7, fas_v);
      `CHK(e, (t > 1) ? 4 : 1)
      `CHK(d, (t % 2) ? 10'h3FF : 10'h001)
    end
    wb(1, CTRL, 16'h0002); wb(1, ERR, 16'h000C); wait_fr(); wb(1, ERR, 16'h000E);
    frames(4, PAY[9:0]); `CHK(e, 1)
    wb(1, CTRL, 0); wb(1, ERR, 16'h0004); wait_fr();
    wb(1, ERR, 16'h0006); wb(1, ERR, 16'h0004); wb(1, ERR, 16'h0006);
    frames(5, fas_v); `CHK(e, 1)
    wb(1, ERR, 0); wb(1, ERR, 16'h0002); frames(4, fas_v); `CHK(e, 0)
    wb(1, ERR, 16'h0005); wb(1, ERR, 16'h0007); frames(4, fas_v); `CHK(e, 0)
    wb(1, ERR, 16'h0005); wait_fr(); ext <= 1'b1; frames(4, fas_v); `CHK(e, 1)
    ext <= 1'b0; frames(3, fas_v); `CHK(e, 0)
  endtask
  initial begin
    for (int i = 0; i < 10; i++) fas_v[i] = FAS_WORD[9 - i];
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_sources();
    t_err();
    end_sim();
  end
endmodule
`default_nettype wire
